// ===== hdl/mpo_pkg.sv
/*
  Constants for the meter pulse output unit: register map, field layout,
  reset values and pulse timing counts.
  Assumes a 125 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package mpo_pkg;

  // ==========================================================================
  // clocking and pulse timing
  // ==========================================================================
  localparam int unsigned CORE_CLK_HZ     = 125_000_000;
  localparam int unsigned PULSE_CLK_HZ    = 2_458_000;
  // core cycles per pulse clock tick
  localparam int unsigned PULSE_DIV       = CORE_CLK_HZ / PULSE_CLK_HZ;
  // pulse interval time in picoseconds (65.772 us)
  localparam longint unsigned PULSE_INTERVAL_PS = 64'd65_772_000;
  // pulse interval in pulse clock ticks, rounded down
  localparam int unsigned PULSE_INTERVAL_TICKS =
    int'((PULSE_INTERVAL_PS * PULSE_CLK_HZ) / 64'd1_000_000_000_000);
  localparam int unsigned DIV_W           = 6;
  localparam int unsigned CNT_W           = 20;
  localparam logic [CNT_W-1:0] CNT_MAX    = 20'hFFFFF;
  localparam logic [CNT_W-1:0] INTERVAL_TICKS = CNT_W'(PULSE_INTERVAL_TICKS);
  localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(PULSE_DIV - 1);

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam int unsigned ADR_W          = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] ADR_DIOCFG = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_MASK   = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_PINS   = 8'h10;

  // ==========================================================================
  // fields and reset values
  // ==========================================================================
  localparam int unsigned CTRL_INV_BIT   = 0;
  localparam int unsigned CTRL_WIDTH_LSB = 8;
  localparam logic        INV_RST        = 1'b0;
  localparam logic [7:0]  WIDTH_RST      = 8'hFF;
  localparam logic [7:0]  WIDTH_NOLIMIT  = 8'hFF;
  localparam logic [7:0]  DIOCFG_RST     = 8'h00;
  localparam logic [3:0]  EVT_RST        = 4'h0;

  // per-pin 2-bit configuration field
  localparam logic [1:0]  PIN_HIZ        = 2'h0;
  localparam logic [1:0]  PIN_PULSE      = 2'h1;
  localparam logic [1:0]  PIN_LOW        = 2'h2;
  localparam logic [1:0]  PIN_HIGH       = 2'h3;

  // pin and event index: real, reactive, zero crossing, sag
  localparam int unsigned IDX_REAL       = 0;
  localparam int unsigned IDX_REACTIVE   = 1;
  localparam int unsigned IDX_ZERO       = 2;
  localparam int unsigned IDX_SAG        = 3;

endpackage : mpo_pkg

// ===== hdl/mpo_meter_pulse_outputs.sv
/*
  Pulse output unit: four pulse outputs driven by metering engine requests,
  shared polarity control, energy pulse width limiting, pin routing with
  per-pin configuration, sticky event status with interrupt, Wishbone slave.
  Assumes the engine inputs are synchronous to I_CORE_CLK and the pin
  inputs are asynchronous.
*/
// The address map and the Wishbone register port were left to the implementer.
// Overview of operation
// (RULE1) four independent pulse outputs whose meaning comes from the engine program
// (RULE2) only the two energy outputs get width hardware; others follow engine directly
// (RULE3) one invert bit flips all four outputs to active high
// (RULE4) invert bit resets to zero, giving active low pulses
// (RULE5) energy pulse maximum low width is (2*setting+1) pulse intervals
// (RULE6) pulse interval defaults to 65.772 microseconds
// (RULE7) width setting 255 disables limiting and gives 50 percent duty
// (RULE8) software normally programs setting 76 for about 10 ms width
// (RULE9) zero crossing output pulses at each voltage zero crossing
// (RULE10) sag output pulses whenever a voltage sag is detected
// (RULE11) reactive output pulses per programmed reactive energy quantum
// (RULE12) real output pulses per programmed real energy quantum
// (RULE13) zero crossing and sag outputs change at most once per engine pass
// (RULE14) zero crossing goes to third pin, sag to fourth pin
// (RULE15) real energy goes to first pin, reactive energy to second pin
// (RULE16) all four pins are high impedance after reset until configured
// (RULE17) each pin has its own configuration field
// (RULE18) active pulse is shortened so successive pulses never merge
`timescale 1ns/10ps
`default_nettype none

module mpo_meter_pulse_outputs (
  input  wire logic                       I_CORE_CLK,        // core clock 125 MHz
  input  wire logic                       I_RESETN,          // async reset, active low
  input  wire logic [mpo_pkg::ADR_W-1:0]  I_WB_ADR,          // wishbone byte address
  input  wire logic [31:0]                I_WB_DAT,          // wishbone write data
  input  wire logic [3:0]                 I_WB_SEL,          // wishbone byte enables
  input  wire logic                       I_WB_WE,           // wishbone write enable
  input  wire logic                       I_WB_CYC,          // wishbone cycle
  input  wire logic                       I_WB_STB,          // wishbone strobe
  output logic [31:0]                     O_WB_DAT,          // wishbone read data
  output logic                            O_WB_ACK,          // wishbone acknowledge
  input  wire logic                       I_ENGINE_PASS,     // one pulse per engine pass
  input  wire logic                       I_ZERO_CROSS_REQ,  // engine zero crossing level
  input  wire logic                       I_SAG_REQ,         // engine sag level
  input  wire logic                       I_REACTIVE_REQ,    // reactive quantum event
  input  wire logic                       I_REAL_REQ,        // real quantum event
  input  wire logic [3:0]                 I_DIO_IN,          // pin levels, asynchronous
  output logic [3:0]                      O_DIO_OUT,         // pin output levels
  output logic [3:0]                      O_DIO_OE,          // pin output enables
  output logic                            O_IRQ              // interrupt, active high
);
  import mpo_pkg::*;

  // ==========================================================================
  // functions
  // ==========================================================================
  // byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    // disabled lanes keep the old byte
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // active width limit in pulse ticks for one energy channel
  function automatic logic [CNT_W-1:0] width_limit(input logic [7:0]       setting,
                                                   input logic [CNT_W-1:0] half_iv);
    logic [CNT_W-1:0] tmax;
    // (RULE6) interval in ticks
    tmax = CNT_W'(({setting, 1'b1}) * INTERVAL_TICKS);
    // 255: only the merge guard
    if (setting == WIDTH_NOLIMIT) begin
      return half_iv;
    end
    return (tmax < half_iv) ? tmax : half_iv;
  endfunction : width_limit

  // ==========================================================================
  // wishbone slave
  // ==========================================================================
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        inv_q;
  logic [7:0]  width_q;
  logic [7:0]  diocfg_q;
  logic [3:0]  status_q;
  logic [3:0]  mask_q;
  logic [3:0]  events;
  logic [3:0]  pins_meta_q;
  logic [3:0]  pins_q;
  logic        wb_req;
  logic        wr_en;
  logic [31:0] ctrl_img;
  logic [31:0] ctrl_new;

  // ack blocks a second take
  assign wb_req   = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wr_en    = wb_req & I_WB_WE;
  assign ctrl_img = {16'h0000, width_q, 7'h00, inv_q};
  // write data merged per lane
  assign ctrl_new = lane_merge(ctrl_img, I_WB_DAT, I_WB_SEL);

  // answer one cycle later
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // registered read data
  // unmapped addresses read zero and ignore writes
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdat_q <= 32'h0000_0000;
    end else if (wb_req && !I_WB_WE) begin
      case (I_WB_ADR)
        ADR_CTRL:   rdat_q <= ctrl_img;
        ADR_DIOCFG: rdat_q <= {24'h000000, diocfg_q};
        ADR_STATUS: rdat_q <= {28'h0000000, status_q};
        ADR_MASK:   rdat_q <= {28'h0000000, mask_q};
        ADR_PINS:   rdat_q <= {28'h0000000, pins_q};
        default:    rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  // ==========================================================================
  // control registers
  // ==========================================================================
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      // (RULE4) invert clear
      inv_q   <= INV_RST;
      width_q <= WIDTH_RST;
    end else if (wr_en && I_WB_ADR == ADR_CTRL) begin
      // (RULE3) one invert bit
      inv_q   <= ctrl_new[CTRL_INV_BIT];
      // (RULE5) width setting
      width_q <= ctrl_new[CTRL_WIDTH_LSB +: 8];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      // (RULE16) pins start hi-z
      diocfg_q <= DIOCFG_RST;
    end else if (wr_en && I_WB_ADR == ADR_DIOCFG && I_WB_SEL[0]) begin
      // 2-bit field per pin
      diocfg_q <= I_WB_DAT[7:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      mask_q <= EVT_RST;
    end else if (wr_en && I_WB_ADR == ADR_MASK && I_WB_SEL[0]) begin
      // status bit layout
      mask_q <= I_WB_DAT[3:0];
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      status_q <= EVT_RST;
    end else if (wr_en && I_WB_ADR == ADR_STATUS && I_WB_SEL[0]) begin
      status_q <= (status_q & ~I_WB_DAT[3:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // level irq, one cycle lag
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(status_q & mask_q);
    end
  end

  // pin read-back synchroniser
  // only stage two is read
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pins_meta_q <= 4'h0;
      pins_q      <= 4'h0;
    end else begin
      pins_meta_q <= I_DIO_IN;
      pins_q      <= pins_meta_q;
    end
  end

  // ==========================================================================
  // pulse clock tick
  // ==========================================================================
  logic [DIV_W-1:0] div_q;
  logic             tick;

  // divider rounds down
  assign tick = (div_q == DIV_LAST);

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + DIV_W'(1);
    end
  end

  // ==========================================================================
  // zero crossing and sag outputs
  // ==========================================================================
  logic zero_q;
  logic sag_q;

  // engine holds each level
  // (RULE2) engine drives these directly
  // (RULE13) update only at a pass boundary
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      zero_q <= 1'b0;
      sag_q  <= 1'b0;
    end else if (I_ENGINE_PASS) begin
      // (RULE9) zero crossing pulse
      zero_q <= I_ZERO_CROSS_REQ;
      // (RULE10) sag pulse
      sag_q  <= I_SAG_REQ;
    end
  end

  // ==========================================================================
  // energy pulse generators
  // ==========================================================================
  logic [1:0]       e_req;
  logic [1:0]       e_act_q;
  logic [1:0]       e_pend_q;
  logic [CNT_W-1:0] e_cnt_q  [2];
  logic [CNT_W-1:0] e_half_q [2];

  // one-cycle engine strobes
  // (RULE11) reactive quantum request
  // (RULE12) real quantum request
  assign e_req = {I_REACTIVE_REQ, I_REAL_REQ};

  // (RULE1) independent generator per energy output
  for (genvar g = 0; g < 2; g++) begin : g_energy
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        e_act_q[g]  <= 1'b0;
        e_pend_q[g] <= 1'b0;
        // first pulse: no prior interval
        e_cnt_q[g]  <= CNT_MAX;
        e_half_q[g] <= CNT_MAX;
      end else if (e_req[g]) begin
        // (RULE18) force a gap on back-to-back pulses
        e_act_q[g]  <= ~e_act_q[g];
        e_pend_q[g] <= e_act_q[g];
        // restart, keep half the interval
        e_cnt_q[g]  <= '0;
        e_half_q[g] <= e_cnt_q[g] >> 1;
      end else if (e_pend_q[g]) begin
        // idle cycle done, restart pulse
        e_act_q[g]  <= 1'b1;
        e_pend_q[g] <= 1'b0;
      end else if (tick) begin
        // saturate, never wrap
        e_cnt_q[g] <= (e_cnt_q[g] == CNT_MAX) ? CNT_MAX : e_cnt_q[g] + CNT_W'(1);
        // (RULE5) maximum width
        // (RULE7) half-interval at 255
        if (e_cnt_q[g] >= width_limit(width_q, e_half_q[g])) begin
          e_act_q[g] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // events and pin drivers
  // ==========================================================================
  // active levels, pin order
  logic [3:0] act;

  // (RULE15) real first, reactive second
  assign act[IDX_REAL]     = e_act_q[0];
  assign act[IDX_REACTIVE] = e_act_q[1];
  // (RULE14) third and fourth pins
  assign act[IDX_ZERO]     = zero_q;
  assign act[IDX_SAG]      = sag_q;

  assign events[IDX_REAL]     = I_REAL_REQ;
  assign events[IDX_REACTIVE] = I_REACTIVE_REQ;
  // rising level only
  assign events[IDX_ZERO]     = I_ENGINE_PASS & I_ZERO_CROSS_REQ & ~zero_q;
  assign events[IDX_SAG]      = I_ENGINE_PASS & I_SAG_REQ & ~sag_q;

  // pins lag generators a cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DIO_OUT <= 4'h0;
      O_DIO_OE  <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        // (RULE17) per-pin field
        case (diocfg_q[p*2 +: 2])
          PIN_PULSE: begin
            // (RULE3) shared polarity, (RULE15) pin order
            O_DIO_OUT[p] <= inv_q ? act[p] : ~act[p];
            O_DIO_OE[p]  <= 1'b1;
          end
          PIN_LOW: begin
            O_DIO_OUT[p] <= 1'b0;
            O_DIO_OE[p]  <= 1'b1;
          end
          PIN_HIGH: begin
            O_DIO_OUT[p] <= 1'b1;
            O_DIO_OE[p]  <= 1'b1;
          end
          // released: low, no drive
          default: begin
            O_DIO_OUT[p] <= 1'b0;
            O_DIO_OE[p]  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : mpo_meter_pulse_outputs

`default_nettype wire

// ===== tb/mpo_pin_partner.sv
/*
  Pin-side partner: LEDs and host inputs with a pull-up on each digital pin.
  Assumes the design raises an enable while it drives that pin.
*/
`timescale 1ns/10ps
`default_nettype none
module mpo_pin_partner (
  input  wire logic [3:0] i_pin_out,  // design pin levels
  input  wire logic [3:0] i_pin_oe,   // design drive enables
  output logic      [3:0] o_pin_wire  // resolved wire levels
);
  // ==========================================================================
  // wire resolution
  // ==========================================================================
  // released pins rest at the pull-up level
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pin_wire[k] = i_pin_oe[k] ? i_pin_out[k] : 1'b1;
    end
  end
endmodule : mpo_pin_partner
`default_nettype wire

// ===== tb/mpo_meter_pulse_outputs_sva.sv
/*
  Checker for the meter pulse output unit, bound to its top module.
  Assumes a classic single-cycle Wishbone master on the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module mpo_meter_pulse_outputs_sva (
  input wire logic                      I_CORE_CLK,       // clock
  input wire logic                      I_RESETN,         // reset
  input wire logic [mpo_pkg::ADR_W-1:0] I_WB_ADR,         // address
  input wire logic [31:0]               I_WB_DAT,         // write data
  input wire logic [3:0]                I_WB_SEL,         // byte enables
  input wire logic                      I_WB_WE,          // write
  input wire logic                      I_WB_CYC,         // cycle
  input wire logic                      I_WB_STB,         // strobe
  input wire logic                      O_WB_ACK,         // acknowledge
  input wire logic                      I_ENGINE_PASS,    // engine pass
  input wire logic                      I_ZERO_CROSS_REQ, // zero level
  input wire logic                      I_SAG_REQ,        // sag level
  input wire logic                      I_REACTIVE_REQ,   // reactive event
  input wire logic                      I_REAL_REQ,       // real event
  input wire logic [3:0]                O_DIO_OUT,        // pin levels
  input wire logic [3:0]                O_DIO_OE          // pin enables
);
  import mpo_pkg::*;
  // ==========================================================================
  // register shadows
  // ==========================================================================
  logic [7:0]  cfg_q, cfg_p, cfg_pp, wid_q;
  logic        inv_q, inv_p, inv_pp, cs;
  logic [31:0] act_n, lim;
  logic [3:0]  oe_x;
  wire logic   wr_c = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK;
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cfg_q <= DIOCFG_RST;
      inv_q <= INV_RST;
      wid_q <= WIDTH_RST;
    end else if (wr_c) begin
      if (I_WB_ADR == ADR_DIOCFG && I_WB_SEL[0]) cfg_q <= I_WB_DAT[7:0];
      if (I_WB_ADR == ADR_CTRL && I_WB_SEL[0]) inv_q <= I_WB_DAT[CTRL_INV_BIT];
      if (I_WB_ADR == ADR_CTRL && I_WB_SEL[1]) wid_q <= I_WB_DAT[15:8];
    end
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      {cfg_p, cfg_pp, inv_p, inv_pp} <= {DIOCFG_RST, DIOCFG_RST, INV_RST, INV_RST};
    end else begin
      {cfg_p, cfg_pp, inv_p, inv_pp} <= {cfg_q, cfg_p, inv_q, inv_p};
    end
  end
  // active cycles of the real energy pin in pulse mode
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) act_n <= '0;
    else if (cs && cfg_q[1:0] == PIN_PULSE && O_DIO_OUT[0] == inv_q) act_n <= act_n + 1;
    else act_n <= '0;
  end
  assign cs = cfg_q == cfg_pp && cfg_p == cfg_pp && inv_q == inv_pp && inv_p == inv_pp;
  assign oe_x = {|cfg_q[7:6], |cfg_q[5:4], |cfg_q[3:2], |cfg_q[1:0]};
  assign lim = (wid_q == WIDTH_NOLIMIT) ? 32'hFFFFFFFF
             : (32'(wid_q) * 2 + 1) * PULSE_DIV * PULSE_INTERVAL_TICKS + 120;
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_taken;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_real_idle;
    I_REAL_REQ && !$past(I_REAL_REQ) && !$past(I_REAL_REQ, 2) && cs
      && cfg_q[1:0] == PIN_PULSE && O_DIO_OUT[0] != inv_q;
  endsequence
  sequence s_reac_idle;
    I_REACTIVE_REQ && !$past(I_REACTIVE_REQ) && !$past(I_REACTIVE_REQ, 2) && cs
      && cfg_q[3:2] == PIN_PULSE && O_DIO_OUT[1] != inv_q;
  endsequence
  AST_ACK_ONE: assert property (s_taken |=> O_WB_ACK)
    else $error("request not acknowledged in the next cycle");
  AST_ACK_DROP: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("acknowledge held longer than one cycle");
  AST_PIN_OE: assert property (cs |-> O_DIO_OE == oe_x)
    else $error("pin enables disagree with pin configuration");
  AST_REAL_START: assert property (s_real_idle |-> ##2 O_DIO_OUT[0] == inv_q)
    else $error("real energy pulse missing on first pin");
  AST_REAC_START: assert property (s_reac_idle |-> ##2 O_DIO_OUT[1] == inv_q)
    else $error("reactive energy pulse missing on second pin");
  AST_ZERO_PIN: assert property (I_ENGINE_PASS && cs && cfg_q[5:4] == PIN_PULSE
    |-> ##2 O_DIO_OUT[2] == ($past(I_ZERO_CROSS_REQ, 2) ~^ inv_q))
    else $error("zero crossing pin does not follow engine level");
  AST_SAG_PIN: assert property (I_ENGINE_PASS && cs && cfg_q[7:6] == PIN_PULSE
    |-> ##2 O_DIO_OUT[3] == ($past(I_SAG_REQ, 2) ~^ inv_q))
    else $error("sag pin does not follow engine level");
  AST_ZS_ONCE: assert property (cs && cfg_q[7:4] == 4'h5 && $changed(O_DIO_OUT[3:2])
    |-> $past(I_ENGINE_PASS, 2))
    else $error("zero or sag pin changed without an engine pass");
  AST_MAX_WIDTH: assert property (act_n <= lim)
    else $error("energy pulse longer than its maximum width");
endmodule : mpo_meter_pulse_outputs_sva
bind mpo_meter_pulse_outputs mpo_meter_pulse_outputs_sva mpo_meter_pulse_outputs_sva_inst (
  .I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .I_WB_ADR(I_WB_ADR),
  .I_WB_DAT(I_WB_DAT), .I_WB_SEL(I_WB_SEL), .I_WB_WE(I_WB_WE), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .I_ENGINE_PASS(I_ENGINE_PASS),
  .I_ZERO_CROSS_REQ(I_ZERO_CROSS_REQ), .I_SAG_REQ(I_SAG_REQ),
  .I_REACTIVE_REQ(I_REACTIVE_REQ), .I_REAL_REQ(I_REAL_REQ),
  .O_DIO_OUT(O_DIO_OUT), .O_DIO_OE(O_DIO_OE));
`default_nettype wire

// ===== tb/tb_meter_pulse_outputs.sv
/*
  Self-checking bench for the meter pulse output unit.
  Assumes pulled-up pins on the partner side and a 125 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_meter_pulse_outputs;
  import mpo_pkg::*;
  logic clk, rstn, we, cyc, stb, pass, zr, sg, req_v, req_r, ack, irq;
  logic [ADR_W-1:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0] sel, din, dout, doe;
  int fail_count, n_tests, wcnt, s;
  logic [31:0] rq[$];
  int wexp[$];
  mpo_meter_pulse_outputs mpo_meter_pulse_outputs_inst (
    .I_CORE_CLK(clk), .I_RESETN(rstn), .I_WB_ADR(adr), .I_WB_DAT(dat), .I_WB_SEL(sel),
    .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_ENGINE_PASS(pass), .I_ZERO_CROSS_REQ(zr), .I_SAG_REQ(sg), .I_REACTIVE_REQ(req_v),
    .I_REAL_REQ(req_r), .I_DIO_IN(din), .O_DIO_OUT(dout), .O_DIO_OE(doe), .O_IRQ(irq));
  mpo_pin_partner mpo_pin_partner_inst (.i_pin_out(dout), .i_pin_oe(doe), .o_pin_wire(din));
  // ==========================================================================
  // compare and bus tasks
  // ==========================================================================
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_w(input int got, input int exp);
    n_tests++;
    if (got > exp + 120 || got + 120 < exp) begin
      fail_count++;
      $display("[FAIL] %0t width %0d expected %0d", $time, got, exp);
    end
  endtask : chk_w
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    adr <= a;
    dat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 32'h0, 1'b0);
  endtask : rd
  task automatic ereq(input logic v, input logic r);
    req_v <= v;
    req_r <= r;
    @(posedge clk);
    req_v <= 1'b0;
    req_r <= 1'b0;
  endtask : ereq
  task automatic epass(input logic z, input logic g);
    zr <= z;
    sg <= g;
    pass <= 1'b1;
    @(posedge clk);
    pass <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : epass
  // two real requests gap cycles apart: first cut by the second, second halved
  task automatic pair(input int gap);
    wexp.push_back(gap);
    wexp.push_back(gap / 2);
    ereq(1'b0, 1'b1);
    repeat (gap - 1) @(posedge clk);
    ereq(1'b0, 1'b1);
    repeat (gap + 200) @(posedge clk);
  endtask : pair
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ==========================================================================
  // monitors, clock and watchdog
  // ==========================================================================
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) chk_rd(rdat, rq.pop_front());
  end
  always @(posedge clk) begin
    if (doe[0] === 1'b1 && dout[0] === 1'b0) wcnt <= wcnt + 1;
    else begin
      if (wcnt > 0 && wexp.size() > 0) chk_w(wcnt, wexp.pop_front());
      wcnt <= 0;
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    {rstn, we, cyc, stb, pass, zr, sg, req_v, req_r} = '0;
    {adr, dat, sel} = {8'h00, 32'h0, 4'hF};
    {fail_count, n_tests, wcnt} = '0;
    void'($urandom(32'hD4ADFE80));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_pin(doe, 4'h0);
    rd(ADR_CTRL, {16'h0, WIDTH_RST, 7'h0, INV_RST});
    rd(8'h20, 32'h0);
    rd(ADR_DIOCFG, 32'h0);
    bus(ADR_DIOCFG, 32'h55, 1'b1);
    repeat (3) @(posedge clk);
    chk_pin(doe, 4'hF);
    chk_pin(dout, 4'hF);
    $display("reset and pin setup done");
    bus(ADR_CTRL, 32'h0, 1'b1);
    wexp.push_back(int'(INTERVAL_TICKS) * int'(PULSE_DIV));
    ereq(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    chk_pin(dout, 4'hC);
    repeat (8300) @(posedge clk);
    bus(ADR_CTRL, 32'h4C00, 1'b1);
    rd(ADR_CTRL, 32'h4C00);
    $display("energy width done");
    epass(1'b1, 1'b0);
    chk_pin(dout[3:2], 2'b10);
    epass(1'b0, 1'b1);
    chk_pin(dout[3:2], 2'b01);
    zr <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pin(dout[3:2], 2'b01);
    epass(1'b0, 1'b0);
    bus(ADR_CTRL, 32'h1, 1'b1);
    repeat (3) @(posedge clk);
    chk_pin(dout, 4'h0);
    epass(1'b1, 1'b1);
    chk_pin(dout, 4'hC);
    epass(1'b0, 1'b0);
    bus(ADR_CTRL, 32'h0, 1'b1);
    repeat (2) @(posedge clk);
    $display("engine pins and polarity done");
    s = 2000 + $urandom_range(1000);
    pair(s);
    repeat (12000) @(posedge clk);
    bus(ADR_CTRL, 32'hFF00, 1'b1);
    s = 3000 + $urandom_range(2000);
    pair(s);
    $display("spacing and duty done");
    rd(ADR_STATUS, 32'hF);
    bus(ADR_STATUS, 32'hF, 1'b1);
    rd(ADR_STATUS, 32'h0);
    bus(ADR_MASK, 32'h1, 1'b1);
    chk_pin(irq, 1'b0);
    ereq(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk_pin(irq, 1'b1);
    bus(ADR_MASK, 32'h0, 1'b1);
    repeat (2) @(posedge clk);
    chk_pin(irq, 1'b0);
    bus(ADR_STATUS, 32'h1, 1'b1);
    bus(ADR_MASK, 32'h1, 1'b1);
    repeat (2) @(posedge clk);
    chk_pin(irq, 1'b0);
    bus(ADR_DIOCFG, 32'hEE, 1'b1);
    repeat (4) @(posedge clk);
    chk_pin(dout, 4'hA);
    rd(ADR_PINS, 32'hA);
    bus(ADR_DIOCFG, 32'h0, 1'b1);
    repeat (4) @(posedge clk);
    chk_pin(doe, 4'h0);
    rd(ADR_PINS, 32'hF);
    $display("interrupt and pin modes done");
    close_out();
  end
endmodule : tb_meter_pulse_outputs
`default_nettype wire
